/* File: rtl/lsimm_unit.sv */
// Immediate-offset load/store execution unit
// Overview of operation
// (RULE1) Offset mode: address is base plus/minus immediate; base register unchanged.
// (RULE2) Without immediate, the base register value is the address.
// (RULE3) Pre-indexed: address is base plus/minus immediate; sum written back to base.
// (RULE4) Post-indexed: access at base, then base plus/minus immediate written back.
// (RULE5) Sizes byte, halfword, word, two words; narrow loads signed or unsigned.
// (RULE6) Unsigned byte loads zero-extend, signed byte loads sign-extend to 32 bits.
// (RULE7) Unsigned halfword loads zero-extend, signed halfword loads sign-extend.
// (RULE8) Single transfers: immediate -255..4095 offset mode, -255..255 indexed modes.
// (RULE9) Two-word transfers: immediate a multiple of 4 within -1020..1020.
// (RULE10) Two-word transfers also move the second transfer register.
// (RULE11) First word at effective address, second at effective address plus four.
// (RULE12) Software: SP/PC load target only for words; dual targets differ.
// (RULE13) Software: indexed forms use a base differing from transferred registers.
// (RULE14) Software: SP store source only for words; never PC as source or base.
// (RULE15) Software: word loaded into PC has bit 0 set.
// (RULE16) Word load into PC branches to loaded value with bit 0 cleared.
// (RULE17) Software: conditional PC load is last in its conditional block.
// (RULE18) Condition flags are never changed by these operations.
`timescale 1ns/10ps
`include "lsimm_regs.svh"
module lsimm_unit
  import lsimm_pkg::*;
(
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  // Command from decode
  input  wire logic        CMD_VALID,
  input  wire lsimm_cmd_t  CMD,
  input  wire logic [31:0] BASE_VAL,
  input  wire logic [31:0] T1_VAL,
  input  wire logic [31:0] T2_VAL,
  input  wire logic [3:0]  FLAGS_IN,
  output logic             CMD_READY,
  output logic             CMD_REJECT,
  // Memory side
  output logic             MEM_REQ,
  output lsimm_mem_t       MEM,
  input  wire logic        MEM_ACK,
  input  wire logic [31:0] MEM_RDATA,
  // Register writeback
  output logic             RF_WE,
  output logic [3:0]       RF_WADDR,
  output logic [31:0]      RF_WDATA,
  output logic             BRANCH,
  output logic [31:0]      BRANCH_ADDR,
  output logic [3:0]       FLAGS_OUT,
  output logic             DONE
);
  typedef enum logic [2:0] {S_IDLE, S_ACC1, S_ACC2, S_WB} lsimm_state_t;

  lsimm_state_t state_reg, state_next;
  lsimm_cmd_t   cmd_reg, cmd_next;
  logic [31:0]  ea_reg, ea_next, wb_reg, wb_next, t2_reg, t2_next;
  lsimm_mem_t   mem_reg, mem_next;
  logic         req_reg, req_next, rf_we_reg, rf_we_next, br_reg, br_next, done_reg, done_next, rej_reg, rej_next;
  logic [3:0]   rf_addr_reg, rf_addr_next;
  logic [31:0]  rf_data_reg, rf_data_next, br_addr_reg, br_addr_next;
  logic [31:0]  sum, ext_val;
  logic [31:0]  imm_ext;

  function automatic logic imm_ok(input lsimm_cmd_t c);
    logic signed [12:0] v;
    v = $signed(c.imm);
    if (!c.has_imm) imm_ok = 1'b1;
    else if (c.size == LSIMM_DUAL)                                               // RULE9
      imm_ok = (v[1:0] == 2'b00) && (v <= `LSIMM_IMM_DUAL_MAX) && (v >= -`LSIMM_IMM_DUAL_MAX);
    else if (c.mode == LSIMM_OFFSET)                                             // RULE8
      imm_ok = (v <= `LSIMM_IMM_POS_MAX) && (v >= -`LSIMM_IMM_NEG_MIN);
    else
      imm_ok = (v <= `LSIMM_IMM_IDX_MAX) && (v >= -`LSIMM_IMM_NEG_MIN);         // RULE8
  endfunction : imm_ok

  function automatic logic [3:0] strobes(input lsimm_size_t s, input logic [1:0] a);
    case (s)
      LSIMM_BYTE, LSIMM_SBYTE: strobes = 4'h1 << a;
      LSIMM_HALF, LSIMM_SHALF: strobes = a[1] ? 4'hc : 4'h3;
      default:                 strobes = 4'hf;
    endcase
  endfunction : strobes

  lsimm_extend u_ext (
    .raw   (MEM_RDATA),
    .size  (cmd_reg.size),
    .lane  (mem_reg.addr[1:0]),
    .value (ext_val)
  );

  always_comb begin
    imm_ext = CMD.has_imm ? {{19{CMD.imm[12]}}, CMD.imm} : 32'h00000000;  // RULE2
    sum     = BASE_VAL + imm_ext;
    state_next = state_reg; cmd_next = cmd_reg; ea_next = ea_reg; wb_next = wb_reg; t2_next = t2_reg;
    mem_next = mem_reg; req_next = req_reg; rf_we_next = 1'b0; rf_addr_next = rf_addr_reg;
    rf_data_next = rf_data_reg; br_next = 1'b0; br_addr_next = br_addr_reg; done_next = 1'b0; rej_next = 1'b0;
    case (state_reg)
      S_IDLE: begin
        if (CMD_VALID) begin
          if (!imm_ok(CMD)) begin
            rej_next  = 1'b1;
            done_next = 1'b1;
          end else begin
            cmd_next = CMD;
            t2_next  = T2_VAL;
            wb_next  = sum;                                                 // RULE3 RULE4
            ea_next  = (CMD.mode == LSIMM_POST) ? BASE_VAL : sum;           // RULE1 RULE3 RULE4
            mem_next.addr  = (CMD.mode == LSIMM_POST) ? BASE_VAL : sum;
            mem_next.write = !CMD.load_op;
            mem_next.strb  = strobes(CMD.size, mem_next.addr[1:0]);
            case (CMD.size)
              LSIMM_BYTE, LSIMM_SBYTE: mem_next.wdata = {4{T1_VAL[7:0]}};
              LSIMM_HALF, LSIMM_SHALF: mem_next.wdata = {2{T1_VAL[15:0]}};
              default:                 mem_next.wdata = T1_VAL;               // RULE5
            endcase
            req_next   = 1'b1;
            state_next = S_ACC1;
          end
        end
      end
      S_ACC1: begin
        if (MEM_ACK) begin
          if (cmd_reg.load_op) begin
            rf_we_next   = 1'b1;
            rf_addr_next = cmd_reg.transfer_reg;
            rf_data_next = ext_val;                                         // RULE6 RULE7
            if (cmd_reg.transfer_reg == `LSIMM_REG_PC && cmd_reg.size == LSIMM_WORD) begin
              rf_we_next   = 1'b0;
              br_next      = 1'b1;                                          // RULE16
              br_addr_next = {MEM_RDATA[31:1], 1'b0};                       // RULE16
            end
          end
          if (cmd_reg.size == LSIMM_DUAL) begin
            mem_next.addr  = ea_reg + `LSIMM_DUAL_STEP;                     // RULE11
            mem_next.wdata = t2_reg;                                        // RULE10
            state_next     = S_ACC2;
          end else begin
            req_next   = 1'b0;
            state_next = S_WB;
          end
        end
      end
      S_ACC2: begin
        if (MEM_ACK) begin
          if (cmd_reg.load_op) begin
            rf_we_next   = 1'b1;
            rf_addr_next = cmd_reg.second_transfer_reg;                     // RULE10
            rf_data_next = MEM_RDATA;
          end
          req_next   = 1'b0;
          state_next = S_WB;
        end
      end
      S_WB: begin
        if (cmd_reg.mode != LSIMM_OFFSET) begin                             // RULE1
          rf_we_next   = 1'b1;
          rf_addr_next = cmd_reg.base_reg;
          rf_data_next = wb_reg;                                            // RULE3 RULE4
        end
        done_next  = 1'b1;
        state_next = S_IDLE;
      end
      default: state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      state_reg <= S_IDLE; cmd_reg <= '0; ea_reg <= 32'h00000000; wb_reg <= 32'h00000000;
      t2_reg <= 32'h00000000; mem_reg <= '0; req_reg <= 1'b0; rf_we_reg <= 1'b0; rf_addr_reg <= 4'h0;
      rf_data_reg <= 32'h00000000; br_reg <= 1'b0; br_addr_reg <= 32'h00000000; done_reg <= 1'b0;
      rej_reg <= 1'b0;
    end else begin
      state_reg <= state_next; cmd_reg <= cmd_next; ea_reg <= ea_next; wb_reg <= wb_next;
      t2_reg <= t2_next; mem_reg <= mem_next; req_reg <= req_next; rf_we_reg <= rf_we_next;
      rf_addr_reg <= rf_addr_next; rf_data_reg <= rf_data_next; br_reg <= br_next;
      br_addr_reg <= br_addr_next; done_reg <= done_next; rej_reg <= rej_next;
    end
  end

  assign CMD_READY   = (state_reg == S_IDLE);
  assign CMD_REJECT  = rej_reg;
  assign MEM_REQ     = req_reg;
  assign MEM         = mem_reg;
  assign RF_WE       = rf_we_reg;
  assign RF_WADDR    = rf_addr_reg;
  assign RF_WDATA    = rf_data_reg;
  assign BRANCH      = br_reg;
  assign BRANCH_ADDR = br_addr_reg;
  assign FLAGS_OUT   = FLAGS_IN;                                            // RULE18
  assign DONE        = done_reg;

  a_branch_lsb_clear: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE16
    BRANCH |-> (BRANCH_ADDR[0] == 1'b0 && BRANCH_ADDR[31:1] == $past(MEM_RDATA[31:1])))
    else $error("branch target bit 0 not cleared");
  a_dual_second_addr: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE11
    (state_reg == S_ACC1 && MEM_ACK && cmd_reg.size == LSIMM_DUAL) |=> (MEM.addr == $past(ea_reg) + `LSIMM_DUAL_STEP))
    else $error("second word address not plus four");
  a_post_base_addr: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE4
    (CMD_VALID && CMD_READY && imm_ok(CMD) && CMD.mode == LSIMM_POST) |=> (MEM.addr == $past(BASE_VAL)))
    else $error("post-index address not base");
  a_pre_addr_sum: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE3
    (CMD_VALID && CMD_READY && imm_ok(CMD) && CMD.mode == LSIMM_PRE) |=> (MEM.addr == wb_reg))
    else $error("pre-index address differs from writeback");
  a_offset_no_wb: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE1
    (state_reg == S_WB && cmd_reg.mode == LSIMM_OFFSET) |=> !RF_WE)
    else $error("offset mode wrote base");
  a_index_wb_base: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE3
    (state_reg == S_WB && cmd_reg.mode != LSIMM_OFFSET) |=> (RF_WE && RF_WADDR == $past(cmd_reg.base_reg)))
    else $error("indexed mode missing base writeback");
  a_imm_range_rej: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE8
    (CMD_VALID && CMD_READY && CMD.has_imm && CMD.size != LSIMM_DUAL && CMD.mode != LSIMM_OFFSET
     && $signed(CMD.imm) > `LSIMM_IMM_IDX_MAX) |=> (CMD_REJECT && !MEM_REQ))
    else $error("indexed immediate out of range accepted");
  a_dual_align_rej: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE9
    (CMD_VALID && CMD_READY && CMD.has_imm && CMD.size == LSIMM_DUAL && CMD.imm[1:0] != 2'b00)
    |=> CMD_REJECT)
    else $error("unaligned dual immediate accepted");
  a_sbyte_extend: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE6
    (state_reg == S_ACC1 && MEM_ACK && cmd_reg.load_op && cmd_reg.size == LSIMM_SBYTE)
    |=> (RF_WDATA[31:8] == {24{RF_WDATA[7]}}))
    else $error("signed byte not sign-extended");
  a_flags_kept: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE18
    DONE |-> (FLAGS_OUT == FLAGS_IN))
    else $error("flags changed");
endmodule : lsimm_unit

/* File: rtl/lsimm_regs.svh */
// Constants for the immediate-offset load/store unit
`ifndef LSIMM_REGS_SVH
`define LSIMM_REGS_SVH
`define LSIMM_IMM_POS_MAX    13'sd4095
`define LSIMM_IMM_NEG_MIN    13'sd255
`define LSIMM_IMM_IDX_MAX    13'sd255
`define LSIMM_IMM_DUAL_MAX   13'sd1020
`define LSIMM_DUAL_STEP      32'h00000004
`define LSIMM_REG_SP         4'hd
`define LSIMM_REG_PC         4'hf
`endif

/* File: rtl/lsimm_pkg.sv */
// Types for the immediate-offset load/store unit
package lsimm_pkg;
  typedef enum logic [1:0] {LSIMM_OFFSET, LSIMM_PRE, LSIMM_POST} lsimm_mode_t;
  typedef enum logic [2:0] {LSIMM_BYTE, LSIMM_SBYTE, LSIMM_HALF, LSIMM_SHALF, LSIMM_WORD, LSIMM_DUAL}
    lsimm_size_t;
  typedef struct packed {
    logic        load_op;
    lsimm_mode_t mode;
    lsimm_size_t size;
    logic        has_imm;
    logic [12:0] imm;
    logic [3:0]  transfer_reg;
    logic [3:0]  second_transfer_reg;
    logic [3:0]  base_reg;
  } lsimm_cmd_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        write;
    logic [3:0]  strb;
  } lsimm_mem_t;
endpackage : lsimm_pkg

/* File: rtl/lsimm_extend.sv */
// Load data extension to register width
`timescale 1ns/10ps
module lsimm_extend
  import lsimm_pkg::*;
(
  // Raw data and size
  input  wire logic [31:0] raw,
  input  wire lsimm_size_t size,
  input  wire logic [1:0]  lane,
  // Extended result
  output logic [31:0]      value
);
  logic [7:0]  byte_sel;
  logic [15:0] half_sel;
  always_comb begin
    byte_sel = raw[{lane, 3'b000} +: 8];
    half_sel = lane[1] ? raw[31:16] : raw[15:0];
    case (size)
      LSIMM_BYTE:  value = {24'h000000, byte_sel};               // RULE6
      LSIMM_SBYTE: value = {{24{byte_sel[7]}}, byte_sel};        // RULE6
      LSIMM_HALF:  value = {16'h0000, half_sel};                 // RULE7
      LSIMM_SHALF: value = {{16{half_sel[15]}}, half_sel};       // RULE7
      default:     value = raw;
    endcase
  end
endmodule : lsimm_extend

/* File: bench/lsimm_mem_model.sv */
// Memory system model answering the unit's data requests
`timescale 1ns/10ps
module lsimm_mem_model
  import lsimm_pkg::*;
(
  // Clock and reset
  input  wire logic       REF_CLK,
  input  wire logic       RST_N,
  // Request side
  input  wire logic       MEM_REQ,
  input  wire lsimm_mem_t MEM,
  input  wire logic [2:0] WAIT_CYC,
  // Answer side
  output logic            MEM_ACK = 1'b0,
  output logic [31:0]     MEM_RDATA = 32'h5a5a5a5a
);
  logic [2:0] cnt_reg = 3'h0;
  // Read data is stale-inverted outside the acknowledge cycle
  always_ff @(posedge REF_CLK) begin
    if (!RST_N || MEM_ACK) begin
      MEM_ACK   <= 1'b0;
      cnt_reg   <= 3'h0;
      MEM_RDATA <= ~MEM_RDATA;
    end else if (MEM_REQ && cnt_reg >= WAIT_CYC) begin
      MEM_ACK   <= 1'b1;
      MEM_RDATA <= 32'h80f07f5b + {MEM.addr[31:2], 2'h0};
    end else begin
      cnt_reg   <= cnt_reg + {2'h0, MEM_REQ};
      MEM_RDATA <= ~MEM_RDATA;
    end
  end
endmodule : lsimm_mem_model

/* File: bench/lsimm_unit_bench.sv */
// Self-checking bench for the immediate-offset load/store unit
`timescale 1ns/10ps
`include "lsimm_regs.svh"
module lsimm_unit_bench import lsimm_pkg::*;;
  typedef struct {lsimm_cmd_t c; logic [31:0] b; logic [31:0] ea; logic rj;} lsimm_row_t;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cmd_valid = 1'b0;
  lsimm_cmd_t  cmd = '0;
  logic [31:0] base_val = '0;
  logic [31:0] t1_val = 32'h9a8b7c6d;
  logic [31:0] t2_val = 32'h13579bdf;
  logic [3:0]  flags_in = '0;
  logic [2:0]  wait_cyc = '0;
  logic        cmd_ready, cmd_reject, mem_req, mem_ack, rf_we, branch, done;
  logic [31:0] mem_rdata, rf_wdata, branch_addr;
  logic [3:0]  rf_waddr, flags_out;
  lsimm_mem_t  mem;
  lsimm_row_t  rows[18];
  int          n_fail = 0;
  int          n_tests = 0;
  always #20 ref_clk = ~ref_clk;
  lsimm_unit uut (.REF_CLK(ref_clk), .RST_N(rst_n), .CMD_VALID(cmd_valid), .CMD(cmd), .BASE_VAL(base_val),
    .T1_VAL(t1_val), .T2_VAL(t2_val), .FLAGS_IN(flags_in), .CMD_READY(cmd_ready), .CMD_REJECT(cmd_reject),
    .MEM_REQ(mem_req), .MEM(mem), .MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata), .RF_WE(rf_we),
    .RF_WADDR(rf_waddr), .RF_WDATA(rf_wdata), .BRANCH(branch), .BRANCH_ADDR(branch_addr),
    .FLAGS_OUT(flags_out), .DONE(done));
  lsimm_mem_model mdl (.REF_CLK(ref_clk), .RST_N(rst_n), .MEM_REQ(mem_req), .MEM(mem),
    .WAIT_CYC(wait_cyc), .MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata));
  function automatic lsimm_row_t mk(logic ld, lsimm_mode_t md, lsimm_size_t z, int im, logic [31:0] b, ea, logic rj);
    lsimm_row_t r;
    r.c = '{ld, md, z, 1'b1, im[12:0], 4'h2, 4'h3, 4'h5};
    r.b = b;
    r.ea = ea;
    r.rj = rj;
    return r;
  endfunction : mk
  function automatic logic [31:0] mdat(logic [31:0] a);
    return 32'h80f07f5b + {a[31:2], 2'h0};
  endfunction : mdat
  function automatic logic [31:0] ext(logic [31:0] d, lsimm_size_t z, logic [1:0] l);
    logic [31:0] s;
    s = d >> {l, 3'h0};
    case (z)
      LSIMM_BYTE:  return {24'h0, s[7:0]};
      LSIMM_SBYTE: return {{24{s[7]}}, s[7:0]};
      LSIMM_HALF:  return {16'h0, s[15:0]};
      LSIMM_SHALF: return {{16{s[15]}}, s[15:0]};
      default:     return d;
    endcase
  endfunction : ext
  function automatic logic [31:0] sexp(lsimm_size_t z, logic [1:0] l);
    if (z == LSIMM_BYTE || z == LSIMM_SBYTE) return 32'h00000001 << l;
    if (z == LSIMM_HALF || z == LSIMM_SHALF) return l[1] ? 32'h0000000c : 32'h00000003;
    return 32'h0000000f;
  endfunction : sexp
  function automatic logic [31:0] wexp(lsimm_size_t z, int n);
    if (z == LSIMM_BYTE) return {4{t1_val[7:0]}};
    if (z == LSIMM_HALF) return {2{t1_val[15:0]}};
    return n == 0 ? t1_val : t2_val;
  endfunction : wexp
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic run(lsimm_row_t r, int i);
    int   nm = 0, nr = 0, nb = 0, nj = 0, nd;
    logic dual, pcl;
    dual = r.c.size == LSIMM_DUAL;
    pcl = r.c.load_op && r.c.transfer_reg == `LSIMM_REG_PC && r.c.size == LSIMM_WORD;
    nd = (r.rj || !r.c.load_op || pcl) ? 0 : (dual ? 2 : 1);
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b1;
    cmd = r.c;
    base_val = r.b;
    flags_in = i[3:0];
    wait_cyc = i[2:0];
    @(negedge ref_clk);
    chk("cmd_ready", 1, cmd_ready);
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b0;
    for (int k = 0; k < 60; k++) begin
      @(negedge ref_clk);
      if (mem_req && mem_ack) begin
        chk("mem_addr", r.ea + 32'(4 * nm), mem.addr);
        chk("mem_write", !r.c.load_op, mem.write);
        chk("mem_strb", sexp(r.c.size, r.ea[1:0]), mem.strb);
        if (!r.c.load_op) chk("mem_wdata", wexp(r.c.size, nm), mem.wdata);
        nm++;
      end
      if (rf_we) begin
        chk("rf_waddr", nr < nd ? (nr ? 4'h3 : 4'h2) : 4'h5, rf_waddr);
        chk("rf_wdata", nr < nd ? ext(mdat(r.ea + 32'(4 * nr)), r.c.size, r.ea[1:0])
          : r.b + {{19{r.c.imm[12]}}, r.c.imm}, rf_wdata);
        nr++;
      end
      if (branch) chk("branch_addr", mdat(r.ea) & 32'hfffffffe, branch_addr);
      nb += int'(branch);
      nj += int'(cmd_reject);
      if (done) break;
    end
    if (done !== 1'b1) begin
      n_fail++;
      $display("Error done expected 1 seen 0");
      close_out();
    end
    chk("mem_count", r.rj ? 0 : (dual ? 2 : 1), nm);
    chk("rf_count", nd + int'(r.c.mode != LSIMM_OFFSET && !r.rj), nr);
    chk("branch_count", pcl && !r.rj, nb);
    chk("reject", r.rj, nj);
    chk("flags_out", flags_in, flags_out);
    $display("test %0d done", i);
  endtask : run
  initial begin
    rows[0] = mk(1, LSIMM_OFFSET, LSIMM_WORD, 4095, 32'h1001, 32'h2000, 0);
    rows[1] = mk(1, LSIMM_OFFSET, LSIMM_WORD, -256, 32'h1100, 0, 1);
    rows[2] = mk(1, LSIMM_OFFSET, LSIMM_WORD, 0, 32'h1200, 32'h1200, 0);
    rows[2].c.has_imm = 1'b0;
    rows[3] = mk(1, LSIMM_PRE, LSIMM_BYTE, 1, 32'h1300, 32'h1301, 0);
    rows[4] = mk(1, LSIMM_PRE, LSIMM_SBYTE, 255, 32'h1300, 32'h13ff, 0);
    rows[5] = mk(1, LSIMM_PRE, LSIMM_SBYTE, 256, 32'h1300, 0, 1);
    rows[6] = mk(1, LSIMM_POST, LSIMM_HALF, -255, 32'h1402, 32'h1402, 0);
    rows[7] = mk(1, LSIMM_OFFSET, LSIMM_SHALF, 2, 32'h1500, 32'h1502, 0);
    rows[8] = mk(1, LSIMM_POST, LSIMM_SHALF, -256, 32'h1500, 0, 1);
    rows[9] = mk(0, LSIMM_POST, LSIMM_BYTE, 4, 32'h1603, 32'h1603, 0);
    rows[10] = mk(0, LSIMM_OFFSET, LSIMM_HALF, 6, 32'h1600, 32'h1606, 0);
    rows[11] = mk(0, LSIMM_PRE, LSIMM_WORD, -8, 32'h1708, 32'h1700, 0);
    rows[12] = mk(1, LSIMM_OFFSET, LSIMM_DUAL, 1020, 32'h1800, 32'h1bfc, 0);
    rows[13] = mk(1, LSIMM_OFFSET, LSIMM_DUAL, 1024, 32'h1800, 0, 1);
    rows[14] = mk(1, LSIMM_PRE, LSIMM_DUAL, 18, 32'h1800, 0, 1);
    rows[15] = mk(0, LSIMM_POST, LSIMM_DUAL, -1020, 32'h1c00, 32'h1c00, 0);
    rows[16] = mk(1, LSIMM_PRE, LSIMM_DUAL, -1020, 32'h2000, 32'h1c04, 0);
    rows[17] = mk(1, LSIMM_OFFSET, LSIMM_WORD, 8, 32'h2100, 32'h2108, 0);
    rows[17].c.transfer_reg = `LSIMM_REG_PC;
    repeat (6) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    foreach (rows[i]) run(rows[i], i);
    // Reset in mid-transfer with a slow memory, then run a pre-indexed word store
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b1;
    cmd = rows[12].c;
    base_val = rows[12].b;
    wait_cyc = 3'h7;
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b0;
    @(negedge ref_clk);
    chk("busy_mem_req", 1, mem_req);
    @(posedge ref_clk);
    #1;
    rst_n = 1'b0;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk("reset_mem_req", 0, mem_req);
    chk("reset_done", 0, done);
    chk("reset_rf_we", 0, rf_we);
    chk("reset_ready", 1, cmd_ready);
    $display("test reset done");
    @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    run(rows[11], 11);
    close_out();
  end
endmodule : lsimm_unit_bench
